// ---- dv/aocs_bp_model.sv ----
`timescale 1ns/100ps
module aocs_bp_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Scan side
  input  wire logic       svc_valid,
  input  wire logic [7:0] lat,
  output logic            svc_done
);
  logic [7:0] wait_cnt;

  // One done pulse per exchange; lat sets a prompt or a slow module
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 8'h00;
      svc_done <= 1'b0;
    end else begin
      svc_done <= 1'b0;
      if (svc_valid && !svc_done) begin
        if (wait_cnt >= lat) begin
          svc_done <= 1'b1;
          wait_cnt <= 8'h00;
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end
    end
  end
endmodule // aocs_bp_model

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
  import aocs_pkg::*;
  localparam int TK = 20;
  typedef struct packed {
    logic        er;
    logic [31:0] m;
    logic [31:0] e;
  } aocs_note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, w;
  logic        svc_valid, svc_done, task_hi, overlap_fault, sv_d;
  logic [2:0]  svc_slot, fault_slot, cfg_fmt_a, cfg_fmt_b, f;
  logic [5:0]  cfg_rng_a, cfg_rng_b, r;
  logic [1:0]  cfg_err;
  aocs_note_t  nt;
  aocs_note_t  rd_q[$];
  logic [2:0]  svc_q[$];
  int          bad_count, total_checks, cyc, c0, n;
  int          cap[7][4] = '{'{2, 0, 1, 0}, '{3, 0, 1, 1}, '{5, 0, 4, 0}, '{30, 0, 4, 0},
                             '{14, 1, 4, 1}, '{14, 1, 6, 0}, '{13, 1, 3, 1}};

  aocs_top #(.TICK_CYC(TK)) aocs_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .svc_valid(svc_valid), .svc_slot(svc_slot), .svc_done(svc_done), .task_hi(task_hi),
    .overlap_fault(overlap_fault), .fault_slot(fault_slot), .cfg_fmt_a(cfg_fmt_a),
    .cfg_rng_a(cfg_rng_a), .cfg_fmt_b(cfg_fmt_b), .cfg_rng_b(cfg_rng_b), .cfg_err(cfg_err)
  );
  aocs_bp_model aocs_bp_model_i (
    .pclk(pclk), .presetn(presetn), .svc_valid(svc_valid), .lat(lat), .svc_done(svc_done)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Every transfer leaves a note; the monitor judges it at the access edge
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er);
    rd_q.push_back('{er, m, e});
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr_en; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
    apb(1'b1, a, d, 32'h0, 32'h0, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    apb(1'b0, a, 32'h0, e, m, er);
  endtask

  task automatic wait_rise();
    do @(negedge pclk); while (svc_valid !== 1'b0);
    do @(negedge pclk); while (svc_valid !== 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    sv_d <= svc_valid;
    if (psel && penable && pready === 1'b1) begin
      nt = rd_q.pop_front();
      chk("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
      if (!pwrite) begin
        chk("prdata", nt.e & nt.m, prdata & nt.m);
      end
    end
    if (svc_valid === 1'b1 && sv_d !== 1'b1 && svc_q.size() > 0) begin
      chk("svc_slot", {29'h0, svc_q.pop_front()}, {29'h0, svc_slot});
    end
  end

  // Hang guard, well above the several hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("mismatch timeout expected done seen hang");
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    task_hi = 1'b0; lat = 8'h01; presetn = 1'b0;
    void'($urandom(32'ha44a));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0, 32'hffff, 1'b0);
    rd(8'h0c, 32'h0, 32'h1f7f, 1'b0);
    rd(8'h08, 32'h0, 32'h1f, 1'b0);
    for (int i = 0; i < 6; i++) rd(8'(32 + 4 * i), 32'h04, 32'hff, 1'b0);
    rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
    wr(8'h40, 32'hffff, 1'b1);
    rd(8'hfc, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      r = (i == 7) ? 6'h3e : 6'($urandom_range(5));
      w = {21'h0, f, 2'b00, r};
      wr(8'h00, w, 1'b0);
      @(negedge pclk);
      chk("cfg_fmt_a", 32'(f), 32'(cfg_fmt_a));
      chk("cfg_rng_a", 32'(r), 32'(cfg_rng_a));
      chk("cfg_err_a", 32'((f > 3'h3) || (r > 6'h05)), 32'(cfg_err[0]));
      rd(8'h00, w, 32'hffff, 1'b0);
    end
    for (int i = 0; i < 9; i++) begin
      r = (i == 8) ? 6'h3f : 6'(i);
      f = (i == 8) ? 3'h6 : 3'($urandom_range(3));
      wr(8'h04, {21'h0, f, 2'b00, r}, 1'b0);
      @(negedge pclk);
      chk("cfg_fmt_b", 32'(f), 32'(cfg_fmt_b));
      chk("cfg_rng_b", 32'(r), 32'(cfg_rng_b));
      chk("cfg_err_b", 32'((r > 6'h05) || (f > 3'h3)), 32'(cfg_err[1]));
    end
    rd(8'h08, 32'h3, 32'h3, 1'b0);
    wr(8'h00, 32'h0302, 1'b0);
    wr(8'h04, 32'h0005, 1'b0);
    @(negedge pclk);
    chk("cfg_err", 32'h0, 32'(cfg_err));
    for (int i = 0; i < 7; i++) begin
      wr(8'h0c, {19'h0, 5'(cap[i][0]), 1'b0, 1'(cap[i][1]), 6'h01}, 1'b0);
      wr(8'h20, 32'(cap[i][2]), 1'b0);
      rd(8'h08, {29'h0, 1'(cap[i][3]), 2'b00}, 32'h4, 1'b0);
    end
    wr(8'h0c, 32'h0, 1'b0);
    task_hi <= 1'b1;
    wr(8'h24, 32'h1, 1'b0);
    wr(8'h2c, 32'h1, 1'b0);
    wr(8'h0c, 32'h0a, 1'b0);
    repeat (5 * TK) @(posedge pclk);
    @(negedge pclk);
    chk("svc_valid", 32'h0, 32'(svc_valid));
    chk("overlap_fault", 32'h1, 32'(overlap_fault));
    chk("fault_slot", 32'h1, 32'(fault_slot));
    rd(8'h10, 32'h8003_9401, 32'h80ff_ff07, 1'b0);
    task_hi <= 1'b0;
    wr(8'h0c, 32'h0, 1'b0);
    wr(8'h10, 32'h8000_0000, 1'b0);
    rd(8'h10, 32'h0, 32'h8000_0000, 1'b0);
    for (int i = 0; i < 6; i++) wr(8'(32 + 4 * i), 32'h8, 1'b0);
    for (int i = 0; i < 6; i++) svc_q.push_back(3'(i));
    wr(8'h0c, 32'h3f, 1'b0);
    n = 0;
    while (svc_q.size() > 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("svc_left", 32'h0, 32'(svc_q.size()));
    wr(8'h0c, 32'h0, 1'b0);
    wr(8'h30, 32'h3, 1'b0);
    wr(8'h0c, 32'h10, 1'b0);
    wait_rise();
    c0 = cyc;
    wait_rise();
    chk("svc_period", 32'(3 * TK), 32'(cyc - c0));
    wr(8'h0c, 32'h0, 1'b0);
    // slow module overlaps its own service
    lat <= 8'd50;
    wr(8'h28, 32'h2, 1'b0);
    wr(8'h0c, 32'h04, 1'b0);
    repeat (4 * TK) @(posedge pclk);
    @(negedge pclk);
    chk("overlap_fault", 32'h1, 32'(overlap_fault));
    chk("fault_slot", 32'h2, 32'(fault_slot));
    tally_and_finish();
  end
endmodule // tb

// ---- hw/aocs_cfg_check.sv ----
`timescale 1ns/100ps
`include "aocs_consts.svh"
module aocs_cfg_check
  import aocs_pkg::*;
(
  // Stored channel word
  input  wire logic [15:0] cfg,
  // Decoded fields
  output logic [2:0]       fmt,
  output logic [5:0]       rng,
  output logic             ok
);
  assign fmt = cfg[`AOCS_FMT_HI:`AOCS_FMT_LO];
  assign rng = cfg[`AOCS_RNG_HI:`AOCS_RNG_LO];
  assign ok  = (fmt <= `AOCS_FMT_MAX) && (rng <= `AOCS_RNG_MAX);
endmodule // aocs_cfg_check

// ---- hw/aocs_consts.svh ----
// Notes on behaviour
// - Bits 10:8 select output data format
// - Spare format codes raise configuration error
// - Bits 5:0 select output type, range
// - At most four expansion module slots
// - Service each module at its packet interval
// - Missed interval logs overlap minor fault
// - Digital-only capacity: 0.5, 1, 2 ms
// - Analog mix capacity adds 3 ms band
// - High-priority tasks hold off I/O servicing
// - Fault 03/94 names first overlapping slot
`ifndef AOCS_CONSTS_SVH
`define AOCS_CONSTS_SVH

`define AOCS_NSLOT       6
`define AOCS_RPI_W       8
`define AOCS_CH_A_OFS    8'h00
`define AOCS_CH_B_OFS    8'h04
`define AOCS_STAT_OFS    8'h08
`define AOCS_SLOT_OFS    8'h0c
`define AOCS_FAULT_OFS   8'h10
`define AOCS_RPI_OFS     8'h20
`define AOCS_RPI_END     8'h38
`define AOCS_FMT_HI      10
`define AOCS_FMT_LO      8
`define AOCS_RNG_HI      5
`define AOCS_RNG_LO      0
`define AOCS_FMT_MAX     3'h3
`define AOCS_RNG_MAX     6'h05
`define AOCS_CFG_RST     16'h0000
`define AOCS_RPI_RST     8'h04
`define AOCS_FLT_TYPE    8'h03
`define AOCS_FLT_CODE    8'h94
`define AOCS_FLT_CLR_BIT 31
`define AOCS_ANA_BIT     6
`define AOCS_CNT_HI      12
`define AOCS_CNT_LO      8
`define AOCS_CLK_NS      10
`define AOCS_TICK_US     500
`define AOCS_TICK_CYC    (`AOCS_TICK_US * 1000 / `AOCS_CLK_NS)
`define AOCS_CAP_N05     5'h02
`define AOCS_CAP_N1      5'h04
`define AOCS_CAP_N2A     5'h0d
`define AOCS_CAP_T05     8'h01
`define AOCS_CAP_T1      8'h02
`define AOCS_CAP_T2      8'h04
`define AOCS_CAP_T3      8'h06

`endif

// ---- hw/aocs_pkg.sv ----
package aocs_pkg;
`include "aocs_consts.svh"

  typedef logic [`AOCS_NSLOT-1:0][`AOCS_RPI_W-1:0] aocs_rpi_t;

  typedef enum logic [1:0] {
    AOCS_IDLE = 2'b01,
    AOCS_BUSY = 2'b10
  } aocs_st_t;

  typedef struct packed {
    aocs_st_t                              st;
    logic [15:0]                           tick;
    logic [`AOCS_NSLOT-1:0]                pend;
    aocs_rpi_t                             cnt;
    logic [2:0]                            slot;
    logic                                  fv;
    logic [2:0]                            fslot;
  } aocs_sch_t;

  typedef struct packed {
    logic [15:0]                           cha;
    logic [15:0]                           chb;
    logic [`AOCS_NSLOT-1:0]                pres;
    logic                                  analog;
    logic [4:0]                            mcnt;
    aocs_rpi_t                             requested_packet_interval;
    logic [31:0]                           prdata;
  } aocs_top_t;

  // Lowest set bit wins; used for service order and fault reporting
  function automatic logic [2:0] aocs_first(input logic [`AOCS_NSLOT-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `AOCS_NSLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Least interval in 0.5 ms ticks the scan can sustain for cnt modules
  function automatic logic [7:0] aocs_min_rpi(input logic [4:0] cnt, input logic ana);
    logic [7:0] t;
    if (cnt <= `AOCS_CAP_N05) begin
      t = `AOCS_CAP_T05;
    end else if (cnt <= `AOCS_CAP_N1) begin
      t = `AOCS_CAP_T1;
    end else if (!ana || cnt <= `AOCS_CAP_N2A) begin
      t = `AOCS_CAP_T2;
    end else begin
      t = `AOCS_CAP_T3;
    end
    return t;
  endfunction
endpackage

// ---- hw/aocs_scan_sched.sv ----
`timescale 1ns/100ps
`include "aocs_consts.svh"
module aocs_scan_sched
  import aocs_pkg::*;
#(
  parameter int TICK_CYC = `AOCS_TICK_CYC
) (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Control side
  aocs_sched_if.sch  sif
);
  localparam aocs_sch_t SCH_RST = '{st: AOCS_IDLE, default: '0};

  aocs_sch_t              r_reg;
  aocs_sch_t              r_next;
  logic                   tick_ev;
  logic [`AOCS_NSLOT-1:0] ovl;
  logic                   done_now;

  always_comb begin
    r_next   = r_reg;
    tick_ev  = 1'b0;
    ovl      = '0;
    done_now = (r_reg.st == AOCS_BUSY) && sif.svc_done;
    if (r_reg.tick == 16'(TICK_CYC - 1)) begin
      r_next.tick = 16'h0000;
      tick_ev     = 1'b1;
    end else begin
      r_next.tick = r_reg.tick + 16'h0001;
    end
    case (r_reg.st)
      AOCS_IDLE: begin
        if (!sif.task_hi && |r_reg.pend) begin
          r_next.st   = AOCS_BUSY;
          r_next.slot = aocs_first(r_reg.pend);
        end
      end
      AOCS_BUSY: begin
        if (sif.svc_done) begin
          r_next.pend[r_reg.slot] = 1'b0;
          r_next.st               = AOCS_IDLE;
        end
      end
      default: r_next.st = AOCS_IDLE;
    endcase
    for (int i = 0; i < `AOCS_NSLOT; i++) begin
      if (!sif.present[i]) begin
        r_next.cnt[i]  = '0;
        r_next.pend[i] = 1'b0;
      end else if (tick_ev) begin
        if (r_reg.cnt[i] <= 8'h01) begin
          r_next.cnt[i]  = sif.requested_packet_interval[i];
          r_next.pend[i] = 1'b1;
          ovl[i] = r_reg.pend[i] && !(done_now && r_reg.slot == 3'(i));
        end else begin
          r_next.cnt[i] = r_reg.cnt[i] - 8'h01;
        end
      end
    end
    // Set wins over a clear in the same cycle
    if (sif.fault_clr) begin
      r_next.fv = 1'b0;
    end
    if (|ovl && !(r_reg.fv && !sif.fault_clr)) begin
      r_next.fv    = 1'b1;
      r_next.fslot = aocs_first(ovl);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= SCH_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.svc_valid   = (r_reg.st == AOCS_BUSY);
  assign sif.svc_slot    = r_reg.slot;
  assign sif.fault_valid = r_reg.fv;
  assign sif.fault_slot  = r_reg.fslot;

  ////////////////////////////////////////////////////////////////////////////
  a_task_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.st == AOCS_IDLE) && sif.task_hi |=> (r_reg.st == AOCS_IDLE))
    else $error("service started while a task held priority");

  a_fault_first: assert property (@(posedge pclk) disable iff (!presetn)
    (|ovl) && !(r_reg.fv && !sif.fault_clr)
      |=> r_reg.fv && (r_reg.fslot == aocs_first($past(ovl))))
    else $error("overlap not logged with its first slot");

  a_fault_kept: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.fv && !sif.fault_clr |=> r_reg.fv && $stable(r_reg.fslot))
    else $error("reported slot changed before clear");

  a_slot0_reload: assert property (@(posedge pclk) disable iff (!presetn)
    tick_ev && sif.present[0] && (r_reg.cnt[0] <= 8'h01)
      |=> (r_reg.cnt[0] == $past(sif.requested_packet_interval[0])) && r_reg.pend[0])
    else $error("slot 0 interval not reloaded");
endmodule // aocs_scan_sched

// ---- hw/aocs_sched_if.sv ----
`timescale 1ns/100ps
`include "aocs_consts.svh"
interface aocs_sched_if;
  import aocs_pkg::*;
  logic [`AOCS_NSLOT-1:0] present;
  aocs_rpi_t              requested_packet_interval;
  logic                   task_hi;
  logic                   svc_done;
  logic                   fault_clr;
  logic                   svc_valid;
  logic [2:0]             svc_slot;
  logic                   fault_valid;
  logic [2:0]             fault_slot;

  modport ctl (
    output present, requested_packet_interval, task_hi, svc_done, fault_clr,
    input  svc_valid, svc_slot, fault_valid, fault_slot
  );
  modport sch (
    input  present, requested_packet_interval, task_hi, svc_done, fault_clr,
    output svc_valid, svc_slot, fault_valid, fault_slot
  );
endinterface

// ---- hw/aocs_top.sv ----
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "aocs_consts.svh"
module aocs_top
  import aocs_pkg::*;
#(
  parameter int TICK_CYC = `AOCS_TICK_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Backplane scan
  output logic             svc_valid,
  output logic [2:0]       svc_slot,
  input  wire logic        svc_done,
  input  wire logic        task_hi,
  output logic             overlap_fault,
  output logic [2:0]       fault_slot,
  // Channel configuration
  output logic [2:0]       cfg_fmt_a,
  output logic [5:0]       cfg_rng_a,
  output logic [2:0]       cfg_fmt_b,
  output logic [5:0]       cfg_rng_b,
  output logic [1:0]       cfg_err
);
  localparam aocs_top_t TOP_RST = '{
    cha:    `AOCS_CFG_RST,
    chb:    `AOCS_CFG_RST,
    requested_packet_interval:    {`AOCS_NSLOT{`AOCS_RPI_RST}},
    default: '0
  };

  aocs_top_t    r_reg;
  aocs_top_t    r_next;
  aocs_sched_if sif ();

  logic         setup;
  logic         wr;
  logic         acc;
  logic [31:0]  rd;
  logic         bad;
  logic         rpi_hit;
  logic [2:0]   rpi_i;
  logic         ok_a;
  logic         ok_b;
  logic         cap_warn;
  logic [7:0]   min_rpi;

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode, one checker per stored word

  aocs_cfg_check u_chk_a (
    .cfg (r_reg.cha),
    .fmt (cfg_fmt_a),
    .rng (cfg_rng_a),
    .ok  (ok_a)
  );

  aocs_cfg_check u_chk_b (
    .cfg (r_reg.chb),
    .fmt (cfg_fmt_b),
    .rng (cfg_rng_b),
    .ok  (ok_b)
  );

  assign cfg_err = {~ok_b, ~ok_a};

  ////////////////////////////////////////////////////////////////////////////
  // Scan scheduler

  aocs_scan_sched #(
    .TICK_CYC (TICK_CYC)
  ) u_sched (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (sif.sch)
  );

  // slots 2..5 are the four expansion modules
  assign sif.present   = r_reg.pres;
  assign sif.requested_packet_interval       = r_reg.requested_packet_interval;
  assign sif.task_hi   = task_hi;
  assign sif.svc_done  = svc_done;
  assign sif.fault_clr = wr && (paddr == `AOCS_FAULT_OFS) && pwdata[`AOCS_FLT_CLR_BIT];
  assign svc_valid     = sif.svc_valid;
  assign svc_slot      = sif.svc_slot;
  assign overlap_fault = sif.fault_valid;
  assign fault_slot    = sif.fault_slot;

  ////////////////////////////////////////////////////////////////////////////
  // APB: read data is captured in the setup cycle so the slave never waits

  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && !bad;
  assign pready  = 1'b1;
  assign pslverr = acc && bad;
  assign prdata  = r_reg.prdata;
  assign min_rpi = aocs_min_rpi(r_reg.mcnt, r_reg.analog);

  always_comb begin
    r_next   = r_reg;
    rd       = 32'h0000_0000;
    bad      = 1'b0;
    cap_warn = 1'b0;
    rpi_i    = 3'((paddr - `AOCS_RPI_OFS) >> 2);
    rpi_hit  = (paddr >= `AOCS_RPI_OFS) && (paddr < `AOCS_RPI_END) && (paddr[1:0] == 2'h0);
    // analog mix adds the 3 ms band
    for (int i = 0; i < `AOCS_NSLOT; i++) begin
      if (r_reg.pres[i] && (r_reg.requested_packet_interval[i] < min_rpi)) begin
        cap_warn = 1'b1;
      end
    end
    case (paddr)
      `AOCS_CH_A_OFS:  rd = {16'h0000, r_reg.cha};
      `AOCS_CH_B_OFS:  rd = {16'h0000, r_reg.chb};
      `AOCS_STAT_OFS:  rd = {27'h0, svc_valid, overlap_fault, cap_warn, cfg_err};
      `AOCS_SLOT_OFS:  rd = {19'h0, r_reg.mcnt, 1'b0, r_reg.analog, r_reg.pres};
      `AOCS_FAULT_OFS: rd = {overlap_fault, 7'h00, `AOCS_FLT_TYPE, `AOCS_FLT_CODE,
                             5'h00, fault_slot};
      default: begin
        if (rpi_hit) begin
          rd = {24'h00_0000, r_reg.requested_packet_interval[rpi_i]};
        end else begin
          bad = 1'b1;
        end
      end
    endcase
    if (setup && !pwrite) begin
      r_next.prdata = rd;
    end
    if (wr) begin
      case (paddr)
        // undefined bits 15:0 of the channel words are stored as written; the slot word keeps only its fields
        `AOCS_CH_A_OFS: r_next.cha = pwdata[15:0];
        `AOCS_CH_B_OFS: r_next.chb = pwdata[15:0];
        `AOCS_SLOT_OFS: begin
          r_next.pres   = pwdata[`AOCS_NSLOT-1:0];
          r_next.analog = pwdata[`AOCS_ANA_BIT];
          r_next.mcnt   = pwdata[`AOCS_CNT_HI:`AOCS_CNT_LO];
        end
        default: begin
          if (rpi_hit) begin
            r_next.requested_packet_interval[rpi_i] = pwdata[`AOCS_RPI_W-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_fmt_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_A_OFS)
      |=> cfg_fmt_a == $past(pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO]))
    else $error("channel A format does not follow the write");

  a_rng_follow: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_B_OFS)
      |=> cfg_rng_b == $past(pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO]))
    else $error("channel B range does not follow the write");

  a_spare_fmt: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_A_OFS)
      && (pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO] > `AOCS_FMT_MAX) |=> cfg_err[0])
    else $error("spare format did not raise an error");

  a_bad_range: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_B_OFS)
      && (pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO] > `AOCS_RNG_MAX) |=> cfg_err[1])
    else $error("invalid range did not raise an error");

  a_err_hold: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_err[0] && !(wr && (paddr == `AOCS_CH_A_OFS)) |=> cfg_err[0])
    else $error("error dropped without a new word");

  a_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_A_OFS)
      && (pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO] <= `AOCS_FMT_MAX)
      && (pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO] <= `AOCS_RNG_MAX) |=> !cfg_err[0])
    else $error("valid word left the error set");

  a_cap_small: assert property (@(posedge pclk) disable iff (!presetn)
    r_reg.pres[0] && (r_reg.mcnt <= `AOCS_CAP_N05) && (r_reg.requested_packet_interval[0] == 8'h00) |-> cap_warn)
    else $error("interval below 0.5 ms not flagged");

  a_cap_analog: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.pres == 6'h01) && r_reg.analog && (r_reg.mcnt > `AOCS_CAP_N2A)
      && (r_reg.requested_packet_interval[0] == `AOCS_CAP_T3) |-> !cap_warn)
    else $error("3 ms band wrongly flagged");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    acc && (paddr == 8'hfc) |-> pslverr)
    else $error("unmapped address accepted");

  ////////////////////////////////////////////////////////////////////////////
  // Remaining channel field checks, write, read-back and capacity checks

  a_fmt_follow_b: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_B_OFS)
      |=> cfg_fmt_b == $past(pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO]))
    else $error("channel B format does not follow the write");

  a_rng_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_A_OFS)
      |=> cfg_rng_a == $past(pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO]))
    else $error("channel A range does not follow the write");

  a_spare_fmt_b: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_B_OFS)
      && (pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO] > `AOCS_FMT_MAX) |=> cfg_err[1])
    else $error("spare format on channel B did not raise an error");

  a_bad_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_A_OFS)
      && (pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO] > `AOCS_RNG_MAX) |=> cfg_err[0])
    else $error("invalid range on channel A did not raise an error");

  a_err_hold_b: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_err[1] && !(wr && (paddr == `AOCS_CH_B_OFS)) |=> cfg_err[1])
    else $error("channel B error dropped without a new word");

  a_err_clear_b: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_CH_B_OFS)
      && (pwdata[`AOCS_FMT_HI:`AOCS_FMT_LO] <= `AOCS_FMT_MAX)
      && (pwdata[`AOCS_RNG_HI:`AOCS_RNG_LO] <= `AOCS_RNG_MAX) |=> !cfg_err[1])
    else $error("valid word left the channel B error set");

  a_bad_wr_kept: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && pslverr |=> $stable(r_reg))
    else $error("refused write changed a register");

  a_wr_slot: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == `AOCS_SLOT_OFS)
      |=> r_reg.pres == $past(pwdata[`AOCS_NSLOT-1:0]))
    else $error("present mask does not follow the write");

  a_wr_rpi: assert property (@(posedge pclk) disable iff (!presetn)
    wr && rpi_hit
      |=> r_reg.requested_packet_interval[$past(rpi_i)] == $past(pwdata[`AOCS_RPI_W-1:0]))
    else $error("interval does not follow the write");

  a_rd_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && (paddr == `AOCS_CH_A_OFS) |-> prdata == {16'h0000, r_reg.cha})
    else $error("channel A word read back wrong");

  a_rd_stat: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && (paddr == `AOCS_STAT_OFS) |-> prdata[2:0] == {cap_warn, cfg_err})
    else $error("status read back wrong");

  a_rd_fault: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && (paddr == `AOCS_FAULT_OFS)
      |-> (prdata[23:16] == `AOCS_FLT_TYPE) && (prdata[15:8] == `AOCS_FLT_CODE))
    else $error("fault type or code read back wrong");

  a_rd_slot: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && (paddr == `AOCS_SLOT_OFS) |-> prdata[`AOCS_NSLOT-1:0] == r_reg.pres)
    else $error("present mask read back wrong");

  a_rd_rpi: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && rpi_hit |-> prdata == {24'h00_0000, r_reg.requested_packet_interval[rpi_i]})
    else $error("interval read back wrong");

  a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");

  a_rd_stands: assert property (@(posedge pclk) disable iff (!presetn)
    acc && !pwrite |=> prdata == $past(prdata))
    else $error("read data changed before the next read");

  a_cap_digital: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.pres == 6'h01) && !r_reg.analog && (r_reg.mcnt > `AOCS_CAP_N1)
      && (r_reg.requested_packet_interval[0] == `AOCS_CAP_T2) |-> !cap_warn)
    else $error("2 ms digital band wrongly flagged");

  a_cap_mid: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.pres == 6'h01) && (r_reg.mcnt > `AOCS_CAP_N05) && (r_reg.mcnt <= `AOCS_CAP_N1)
      && (r_reg.requested_packet_interval[0] < `AOCS_CAP_T1) |-> cap_warn)
    else $error("interval below 1 ms not flagged");

  a_cap_analog_mid: assert property (@(posedge pclk) disable iff (!presetn)
    (r_reg.pres == 6'h01) && r_reg.analog && (r_reg.mcnt > `AOCS_CAP_N1)
      && (r_reg.mcnt <= `AOCS_CAP_N2A) && (r_reg.requested_packet_interval[0] < `AOCS_CAP_T2) |-> cap_warn)
    else $error("analog interval below 2 ms not flagged");
endmodule // aocs_top
